// ==== fbsg_defines.svh ====
// Purpose: register map, reset values and codes of the frame batch sequencer
// Assumes: AXI4-Lite word registers, 8-bit byte address
// Notes: aclk stands in for the distributed global clock
`ifndef FBSG_DEFINES_SVH
`define FBSG_DEFINES_SVH
`define FB_CTRL 8'h00
`define FB_STATUS 8'h04
`define FB_SLICE_LEN 8'h08
`define FB_FRAME_LEN 8'h0c
`define FB_BATCH_LEN 8'h10
`define FB_SEQ_LEN 8'h14
`define FB_BATCH_GAP 8'h18
`define FB_NEXT_FRAME 8'h1c
`define FB_LAST_FRAME 8'h20
`define FB_CTRL_BEGIN 0
`define FB_CTRL_HALT 1
`define FB_RST_SLICE 32'h0000000a
`define FB_RST_FRAME 32'h00000004
`define FB_RST_BATCH 32'h00000000
`define FB_RST_SEQ 32'h00000000
`define FB_RST_GAP 32'h00000010
`define FB_RST_NEXT 32'h00000000
`define FB_RST_LAST 32'hffffffff
`define FB_RESP_OKAY 2'h0
`define FB_RESP_SLVERR 2'h2
`endif

// ==== fbsg_pkg.sv ====
// Purpose: types of the frame batch sequencer
// Assumes: nothing beyond the defines header
// Notes: one-hot sequencer states
package fbsg_pkg;
    typedef enum logic [3:0] {
        ST_IDLE = 4'h1,
        ST_PRE = 4'h2,
        ST_RUN = 4'h4,
        ST_GAP = 4'h8
    } seq_state_t;
    typedef struct packed {
        logic clk_phase;
        logic preload;
        logic frame_begin;
        logic slice_begin;
        logic [31:0] number;
    } sync_cmd_t;
    typedef struct packed {
        logic valid;
        logic [31:0] frame;
        logic [63:0] time_cnt;
    } stamp_t;
    typedef struct packed {
        logic aw_full;
        logic [7:0] aw_addr;
        logic w_full;
        logic [31:0] w_data;
        logic [3:0] w_strb;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } axi_t;
    typedef struct packed {
        seq_state_t state;
        logic [31:0] slice_len;
        logic [31:0] frame_len;
        logic [31:0] batch_len;
        logic [31:0] seq_len;
        logic [31:0] gap_len;
        logic [31:0] next_frame;
        logic [31:0] last_frame;
        logic [31:0] cyc;
        logic [31:0] slc;
        logic [31:0] frm;
        logic [31:0] bat;
        logic [31:0] gap_cnt;
        logic pre_sent;
        logic halt_pend;
        logic phase;
        logic [63:0] tick;
    } seq_t;
endpackage

// ==== frame_batch_sequence_generator.sv ====
// Purpose: frame batch sequencer issuing preload, frame and slice commands
// Assumes: synchronous active-low reset, AXI4-Lite register access
// Notes: commands and stamps are registered, one cycle per command
`timescale 1ns/1ps
`include "fbsg_defines.svh"
module frame_batch_sequence_generator (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [7:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [7:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    output fbsg_pkg::sync_cmd_t sync_out,
    output fbsg_pkg::stamp_t frame_stamp
);
    import fbsg_pkg::*;

    axi_t a_r, a_nxt;
    seq_t s_r, s_nxt;
    sync_cmd_t cmd_nxt;
    stamp_t stamp_nxt;
    logic wr_fire, wr_map, rd_map, begin_req, halt_req, term;
    logic [31:0] rd_word;
    logic [31:0] sl_eff, fl_eff;
    logic slice_end, frame_end, last_start, end_frame, pre_now;
    logic batch_done, final_hit, seq_done;

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
                                          input logic [3:0] st);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (st[i]) begin
                r[i*8 +: 8] = d[i*8 +: 8];
            end
        end
        return r;
    endfunction

    // Bus handshakes
    assign awready = !a_r.aw_full;
    assign wready = !a_r.w_full;
    assign arready = !a_r.rvalid;
    assign bvalid = a_r.bvalid;
    assign bresp = a_r.bresp;
    assign rvalid = a_r.rvalid;
    assign rdata = a_r.rdata;
    assign rresp = a_r.rresp;
    assign wr_fire = a_r.aw_full && a_r.w_full && !a_r.bvalid;
    assign begin_req = wr_fire && a_r.aw_addr == `FB_CTRL && a_r.w_strb[0] &&
                       a_r.w_data[`FB_CTRL_BEGIN];
    assign halt_req = wr_fire && a_r.aw_addr == `FB_CTRL && a_r.w_strb[0] &&
                      a_r.w_data[`FB_CTRL_HALT];

    // Address decode for both directions
    always_comb begin
        wr_map = 1'b1;
        unique case (a_r.aw_addr)
            `FB_CTRL, `FB_STATUS, `FB_SLICE_LEN, `FB_FRAME_LEN, `FB_BATCH_LEN,
            `FB_SEQ_LEN, `FB_BATCH_GAP, `FB_NEXT_FRAME, `FB_LAST_FRAME: wr_map = 1'b1;
            default: wr_map = 1'b0;
        endcase
        rd_map = 1'b1;
        rd_word = 32'h0;
        unique case (araddr)
            `FB_CTRL: rd_word = 32'h0;
            `FB_STATUS: rd_word = {28'h0, s_r.pre_sent, s_r.halt_pend,
                                   s_r.state == ST_GAP, s_r.state != ST_IDLE};
            `FB_SLICE_LEN: rd_word = s_r.slice_len;
            `FB_FRAME_LEN: rd_word = s_r.frame_len;
            `FB_BATCH_LEN: rd_word = s_r.batch_len;
            `FB_SEQ_LEN: rd_word = s_r.seq_len;
            `FB_BATCH_GAP: rd_word = s_r.gap_len;
            `FB_NEXT_FRAME: rd_word = s_r.next_frame;
            `FB_LAST_FRAME: rd_word = s_r.last_frame;
            default: rd_map = 1'b0;
        endcase
    end

    // AXI4-Lite slave: address and data held independently
    always_comb begin
        a_nxt = a_r;
        if (awvalid && !a_r.aw_full) begin
            a_nxt.aw_full = 1'b1;
            a_nxt.aw_addr = awaddr;
        end
        if (wvalid && !a_r.w_full) begin
            a_nxt.w_full = 1'b1;
            a_nxt.w_data = wdata;
            a_nxt.w_strb = wstrb;
        end
        if (wr_fire) begin
            a_nxt.aw_full = 1'b0;
            a_nxt.w_full = 1'b0;
            a_nxt.bvalid = 1'b1;
            a_nxt.bresp = wr_map ? `FB_RESP_OKAY : `FB_RESP_SLVERR;
        end else if (a_r.bvalid && bready) begin
            a_nxt.bvalid = 1'b0;
        end
        if (arvalid && !a_r.rvalid) begin
            a_nxt.rvalid = 1'b1;
            a_nxt.rdata = rd_word;
            a_nxt.rresp = rd_map ? `FB_RESP_OKAY : `FB_RESP_SLVERR;
        end else if (a_r.rvalid && rready) begin
            a_nxt.rvalid = 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            a_r <= '0;
        end else begin
            a_r <= a_nxt;
        end
    end

    // Zero slice and frame lengths act as one; zero batch and sequence lengths mean no limit
    assign sl_eff = (s_r.slice_len == 32'h0) ? 32'h1 : s_r.slice_len;
    assign fl_eff = (s_r.frame_len == 32'h0) ? 32'h1 : s_r.frame_len;
    assign slice_end = s_r.state == ST_RUN && s_r.cyc == sl_eff - 32'h1;
    assign frame_end = slice_end && s_r.slc == fl_eff - 32'h1;
    assign last_start = s_r.state == ST_RUN && !s_r.pre_sent && s_r.cyc == 32'h0 &&
                        s_r.slc == fl_eff - 32'h1;
    assign batch_done = s_r.batch_len != 32'h0 &&
                        s_r.frm == s_r.batch_len - 32'h1;
    assign final_hit = s_r.next_frame == s_r.last_frame;
    assign seq_done = (s_r.seq_len != 32'h0 && s_r.bat == s_r.seq_len - 32'h1) ||
                      final_hit;
    assign end_frame = batch_done || final_hit || s_r.halt_pend;
    assign pre_now = last_start && !end_frame;

    // Sequencer
    always_comb begin
        s_nxt = s_r;
        cmd_nxt = '0;
        stamp_nxt = '0;
        term = 1'b0;
        s_nxt.tick = s_r.tick + 64'h1;
        s_nxt.phase = !s_r.phase;
        unique case (s_r.state)
            ST_IDLE: begin
                if (begin_req) begin
                    s_nxt.bat = 32'h0;
                    s_nxt.state = ST_PRE;
                end
            end
            ST_PRE: begin
                cmd_nxt.preload = 1'b1;
                cmd_nxt.number = s_r.next_frame;
                s_nxt.next_frame = s_r.next_frame + 32'h1;
                s_nxt.pre_sent = 1'b1;
                s_nxt.cyc = sl_eff - 32'h1;
                s_nxt.slc = fl_eff - 32'h1;
                s_nxt.frm = 32'hffffffff;
                s_nxt.state = ST_RUN;
            end
            ST_RUN: begin
                s_nxt.cyc = s_r.cyc + 32'h1;
                if (pre_now) begin
                    cmd_nxt.preload = 1'b1;
                    cmd_nxt.number = s_r.next_frame;
                    s_nxt.next_frame = s_r.next_frame + 32'h1;
                    s_nxt.pre_sent = 1'b1;
                end
                if (slice_end) begin
                    s_nxt.cyc = 32'h0;
                    if (s_r.halt_pend && !s_r.pre_sent && !pre_now) begin
                        term = 1'b1;
                        s_nxt.state = ST_IDLE;
                    end else if (frame_end) begin
                        s_nxt.slc = 32'h0;
                        if (s_r.pre_sent || pre_now) begin
                            cmd_nxt.frame_begin = 1'b1;
                            s_nxt.frm = s_r.frm + 32'h1;
                            s_nxt.pre_sent = 1'b0;
                            stamp_nxt.valid = 1'b1;
                            stamp_nxt.frame = s_nxt.next_frame - 32'h1;
                            stamp_nxt.time_cnt = s_r.tick;
                        end else begin
                            term = 1'b1;
                            s_nxt.bat = s_r.bat + 32'h1;
                            s_nxt.gap_cnt = 32'h0;
                            s_nxt.state = seq_done ? ST_IDLE : ST_GAP;
                        end
                    end else begin
                        s_nxt.slc = s_r.slc + 32'h1;
                        cmd_nxt.slice_begin = 1'b1;
                    end
                end
            end
            ST_GAP: begin
                s_nxt.gap_cnt = s_r.gap_cnt + 32'h1;
                if (s_r.halt_pend) begin
                    s_nxt.state = ST_IDLE;
                end else if (s_r.gap_len == 32'h0 ||
                             s_r.gap_cnt >= s_r.gap_len - 32'h1) begin
                    s_nxt.state = ST_PRE;
                end
            end
        endcase
        if (term) begin
            cmd_nxt.frame_begin = 1'b1;
        end
        cmd_nxt.clk_phase = s_nxt.phase;
        if (halt_req && s_r.state != ST_IDLE) begin
            s_nxt.halt_pend = 1'b1;
        end
        if (s_nxt.state == ST_IDLE) begin
            s_nxt.halt_pend = 1'b0;
            s_nxt.pre_sent = 1'b0;
        end
        // Software writes win over the preload increment
        if (wr_fire) begin
            unique case (a_r.aw_addr)
                `FB_SLICE_LEN: s_nxt.slice_len = merge(s_r.slice_len, a_r.w_data, a_r.w_strb);
                `FB_FRAME_LEN: s_nxt.frame_len = merge(s_r.frame_len, a_r.w_data, a_r.w_strb);
                `FB_BATCH_LEN: s_nxt.batch_len = merge(s_r.batch_len, a_r.w_data, a_r.w_strb);
                `FB_SEQ_LEN: s_nxt.seq_len = merge(s_r.seq_len, a_r.w_data, a_r.w_strb);
                `FB_BATCH_GAP: s_nxt.gap_len = merge(s_r.gap_len, a_r.w_data, a_r.w_strb);
                `FB_NEXT_FRAME: s_nxt.next_frame = merge(s_r.next_frame, a_r.w_data,
                                                         a_r.w_strb);
                `FB_LAST_FRAME: s_nxt.last_frame = merge(s_r.last_frame, a_r.w_data,
                                                         a_r.w_strb);
                default: ;
            endcase
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_r <= '{state: ST_IDLE, slice_len: `FB_RST_SLICE, frame_len: `FB_RST_FRAME,
                     batch_len: `FB_RST_BATCH, seq_len: `FB_RST_SEQ, gap_len: `FB_RST_GAP,
                     next_frame: `FB_RST_NEXT, last_frame: `FB_RST_LAST, default: '0};
            sync_out <= '0;
            frame_stamp <= '0;
        end else begin
            s_r <= s_nxt;
            sync_out <= cmd_nxt;
            frame_stamp <= stamp_nxt;
        end
    end

    a_preload_incr: assert property (@(posedge aclk) disable iff (!aresetn)
        (cmd_nxt.preload && !wr_fire) |=>
        sync_out.preload && s_r.next_frame == sync_out.number + 32'h1)
        else $error("preload did not advance next frame");

    a_slice_period: assert property (@(posedge aclk) disable iff (!aresetn)
        sync_out.slice_begin |-> s_r.cyc == 32'h0 &&
        $past(s_r.cyc) == $past(sl_eff) - 32'h1)
        else $error("slice begin off its period");

    a_frame_align: assert property (@(posedge aclk) disable iff (!aresetn)
        frame_stamp.valid |-> sync_out.frame_begin && s_r.cyc == 32'h0 &&
        s_r.slc == 32'h0)
        else $error("frame begin not aligned to counters");

    a_bare_term: assert property (@(posedge aclk) disable iff (!aresetn)
        term |-> !s_r.pre_sent && !cmd_nxt.preload)
        else $error("terminator after preload");

    a_begin_start: assert property (@(posedge aclk) disable iff (!aresetn)
        (s_r.state == ST_IDLE && begin_req) |=> s_r.state == ST_PRE ##1
        (sync_out.preload && s_r.state == ST_RUN))
        else $error("begin did not start a batch");

    a_halt_slice: assert property (@(posedge aclk) disable iff (!aresetn)
        (slice_end && s_r.halt_pend && !s_r.pre_sent) |=>
        s_r.state == ST_IDLE && sync_out.frame_begin && !frame_stamp.valid)
        else $error("halt missed slice boundary");

    a_gap_hold: assert property (@(posedge aclk) disable iff (!aresetn)
        (s_r.state == ST_GAP && !s_r.halt_pend && s_r.gap_len != 32'h0 &&
         s_r.gap_cnt < s_r.gap_len - 32'h1) |=> s_r.state == ST_GAP)
        else $error("gap ended early");

    a_batch_stop: assert property (@(posedge aclk) disable iff (!aresetn)
        (frame_end && !s_r.pre_sent && !pre_now && !s_r.halt_pend) |=>
        sync_out.frame_begin && s_r.state != ST_RUN)
        else $error("counted stop not at frame end");

    a_final_nopre: assert property (@(posedge aclk) disable iff (!aresetn)
        (last_start && final_hit) |-> !cmd_nxt.preload)
        else $error("preload past final frame");

    a_stamp_time: assert property (@(posedge aclk) disable iff (!aresetn)
        frame_stamp.valid |-> frame_stamp.time_cnt == s_r.tick - 64'h1)
        else $error("frame stamp time wrong");
endmodule

// ==== first_level_aggregator.sv ====
// Purpose: receiver model of the first level aggregator
// Assumes: each sync command lasts one cycle
// Notes: never misbehaves; only tracks frame state
`timescale 1ns/1ps
module first_level_aggregator (
    input wire logic aclk,
    input wire logic aresetn,
    input wire fbsg_pkg::sync_cmd_t cmd,
    output logic frame_active,
    output logic [31:0] frame_num
);
    import fbsg_pkg::*;
    logic act_r, act_nxt, ok_r, ok_nxt;
    logic [31:0] num_r, num_nxt, up_r, up_nxt;
    always_comb begin
        act_nxt = act_r;
        ok_nxt = ok_r;
        num_nxt = num_r;
        up_nxt = up_r;
        // Preload first: with one-cycle slices it shares a cycle with frame begin
        if (cmd.preload) begin
            up_nxt = cmd.number;
            ok_nxt = 1'b1;
        end
        if (cmd.frame_begin) begin
            if (ok_nxt) begin
                act_nxt = 1'b1;
                num_nxt = up_nxt;
                ok_nxt = 1'b0;
            end else if (act_r) begin
                act_nxt = 1'b0;
            end
        end
    end
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            act_r <= 1'b0;
            ok_r <= 1'b0;
            num_r <= 32'h0;
            up_r <= 32'h0;
        end else begin
            act_r <= act_nxt;
            ok_r <= ok_nxt;
            num_r <= num_nxt;
            up_r <= up_nxt;
        end
    end
    assign frame_active = act_r;
    assign frame_num = num_r;
endmodule

// ==== testbench.sv ====
// Purpose: self-checking bench of the frame batch sequencer
// Assumes: event list model built from the register settings
// Notes: gap spacing is the idle cycles plus the preload cycle
`timescale 1ns/1ps
`include "fbsg_defines.svh"
module testbench;
    import fbsg_pkg::*;
    logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic [7:0] awaddr = 0, araddr = 0;
    logic [31:0] wdata = 0, rdata, d, ls1;
    logic [3:0] wstrb = 4'hf;
    logic awready, wready, bvalid, arready, rvalid, agg_act, ph = 0, up = 0;
    logic [1:0] bresp, rresp, r;
    logic [31:0] agg_num, rst[9], ex_n[$], obs_n[$];
    sync_cmd_t sync_out;
    stamp_t frame_stamp;
    int errors = 0, tests_run = 0, cyc = 0, tl = 0, nobs = 0, rs, cy_prev = -1;
    logic [63:0] st_prev = 0;
    int obs_k[$], obs_t[$], ex_k[$], ex_d[$];
    frame_batch_sequence_generator uut (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr),
        .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
        .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
        .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
        .rready(rready), .sync_out(sync_out), .frame_stamp(frame_stamp));
    first_level_aggregator agg (.aclk(aclk), .aresetn(aresetn), .cmd(sync_out),
        .frame_active(agg_act), .frame_num(agg_num));
    initial begin
        forever #25 aclk = ~aclk;
    end
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            errors++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic stop_test;
        $display("comparisons %0d mismatches %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    task automatic axw(input logic [7:0] a, input logic [31:0] v, output logic [1:0] rr);
        @(posedge aclk);
        awaddr <= a;
        wdata <= v;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        forever begin
            @(posedge aclk);
            if (awvalid && awready === 1'b1) awvalid <= 1'b0;
            if (wvalid && wready === 1'b1) wvalid <= 1'b0;
            if (bvalid === 1'b1) begin
                rr = bresp;
                bready <= 1'b0;
                break;
            end
        end
    endtask
    task automatic axr(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rr);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        forever begin
            @(posedge aclk);
            if (arvalid && arready === 1'b1) arvalid <= 1'b0;
            if (rvalid === 1'b1) begin
                v = rdata;
                rr = rresp;
                rready <= 1'b0;
                break;
            end
        end
    endtask
    // Command log; preload before frame before slice within one cycle
    task automatic lg(input int k, input logic [31:0] n);
        obs_k.push_back(k);
        obs_n.push_back(n);
        obs_t.push_back(cyc);
        nobs++;
    endtask
    always @(posedge aclk) begin
        cyc++;
        if (aresetn && up) chk("phase toggle", sync_out.clk_phase, !ph);
        ph = sync_out.clk_phase;
        up = aresetn;
        if (aresetn) begin
            if (sync_out.preload === 1'b1) lg(1, sync_out.number);
            if (sync_out.frame_begin === 1'b1) lg(2, frame_stamp.valid ? frame_stamp.frame : '1);
            if (sync_out.slice_begin === 1'b1) lg(3, 0);
            if (frame_stamp.valid === 1'b1) begin
                if (cy_prev >= 0) chk("stamp interval", 32'(frame_stamp.time_cnt - st_prev), cyc - cy_prev);
                st_prev = frame_stamp.time_cnt;
                cy_prev = cyc;
            end
        end
    end
    // Expected event; negative time marks the preload after a gap
    task automatic pa(input int k, input int t, input logic [31:0] n);
        ex_k.push_back(k);
        ex_n.push_back(n);
        ex_d.push_back(t < 0 ? -1 : t - tl);
        tl = t < 0 ? 0 : t;
    endtask
    task automatic build(input int s, f, b, q, input logic [31:0] ls, inout logic [31:0] nx);
        int t, nf, bt;
        bit cont;
        t = 0;
        nf = 0;
        bt = 0;
        pa(1, 0, nx);
        forever begin
            pa(2, t + 1, nx);
            nx++;
            nf++;
            cont = nx !== ls && !(b != 0 && nf == b);
            for (int k = 1; k < f - 1; k++) pa(3, t + 1 + k * s, 0);
            if (f > 1) pa(3, t + 1 + (f - 1) * s, 0);
            // Preload one cycle into the last slice
            if (cont) pa(1, t + 2 + (f - 1) * s, nx);
            if (!cont) begin
                pa(2, t + 1 + f * s, '1);
                bt++;
                if (nx === ls || (q != 0 && bt == q)) break;
                nf = 0;
                t = 0;
                pa(1, -1, nx);
            end else begin
                t = t + f * s;
            end
        end
    endtask
    task automatic cmp(input int g);
        int dd;
        chk("event count", obs_k.size(), ex_k.size());
        for (int i = 0; i < ex_k.size() && i < obs_k.size(); i++) begin
            dd = (i == 0) ? 0 : obs_t[i] - obs_t[i-1];
            chk("event kind", obs_k[i], ex_k[i]);
            chk("frame number", obs_n[i], ex_n[i]);
            if (ex_d[i] < 0) chk("gap length", dd, (g > 0 ? g : 1) + 1);
            else chk("event spacing", dd, ex_d[i]);
        end
    endtask
    task automatic cfg(input int s, f, b, q, g, input logic [31:0] nx, ls);
        logic [31:0] v[7];
        logic [1:0] rr;
        v = '{s, f, b, q, g, nx, ls};
        for (int i = 0; i < 7; i++) axw(8'(8 + 4 * i), v[i], rr);
        obs_k.delete();
        obs_n.delete();
        obs_t.delete();
        ex_k.delete();
        ex_n.delete();
        ex_d.delete();
        tl = 0;
        nobs = 0;
    endtask
    task automatic fin(input int g, input logic [31:0] nx);
        logic [31:0] v;
        logic [1:0] rr;
        v = 1;
        while (v[0] !== 1'b0) axr(`FB_STATUS, v, rr);
        cmp(g);
        axr(`FB_NEXT_FRAME, v, rr);
        chk("next frame", v, nx);
        chk("receiver active", agg_act, 0);
        chk("receiver frame", agg_num, nx - 1);
    endtask
    task automatic run(input int s, f, b, q, g, input logic [31:0] nx, ls);
        logic [1:0] rr;
        cfg(s, f, b, q, g, nx, ls);
        build(s, f, b, q, ls, nx);
        axw(`FB_CTRL, 32'h1, rr);
        fin(g, nx);
    endtask
    initial begin
        repeat (40000) @(posedge aclk);
        errors++;
        stop_test;
    end
    initial begin
        rs = $urandom(2855);
        ls1 = '1;
        rst = '{0, 0, `FB_RST_SLICE, `FB_RST_FRAME, `FB_RST_BATCH, `FB_RST_SEQ, `FB_RST_GAP,
            `FB_RST_NEXT, `FB_RST_LAST};
        repeat (5) @(posedge aclk);
        aresetn <= 1'b1;
        for (int i = 0; i < 9; i++) begin
            axr(8'(4 * i), d, r);
            chk("reset value", d, rst[i]);
        end
        axr(8'h40, d, r);
        chk("unmapped read resp", r, `FB_RESP_SLVERR);
        chk("unmapped read data", d, 32'h0);
        axw(8'h40, 32'h5, r);
        chk("unmapped write", r, `FB_RESP_SLVERR);
        for (int i = 2; i < 9; i++) begin
            rs = $urandom;
            axw(8'(4 * i), rs, r);
            axr(8'(4 * i), d, r);
            chk("read back", d, rs);
        end
        run(2, 2, 1, 1, 5, 0, ls1);
        run(3, 2, 2, 2, 4, 10, ls1);
        run(2, 3, 0, 0, 4, 5, 7);
        run(2 + $urandom % 4, 2 + $urandom % 3, 1 + $urandom % 3, 1 + $urandom % 2,
            1 + $urandom % 6, $urandom % 1000, ls1);
        // One-cycle slices and frames: preload shares the cycle of frame begin
        run(1, 1, 3, 1, 2, 20, ls1);
        // Halt during the batch gap: back to idle with no further command
        cfg(2, 1, 1, 0, 50, 0, ls1);
        pa(1, 0, 0);
        pa(2, 1, 0);
        pa(2, 3, '1);
        axw(`FB_CTRL, 32'h1, r);
        wait (nobs == 3);
        axw(`FB_CTRL, 32'h2, r);
        fin(50, 1);
        // Halt inside the first slice, no preload out yet
        cfg(8, 4, 0, 0, 1, 0, ls1);
        pa(1, 0, 0);
        pa(2, 1, 0);
        pa(2, 9, '1);
        axw(`FB_CTRL, 32'h1, r);
        wait (nobs == 2);
        axw(`FB_CTRL, 32'h2, r);
        fin(1, 1);
        // Halt after the preload: one more frame, one slice long
        cfg(8, 2, 0, 0, 1, 0, ls1);
        pa(1, 0, 0);
        pa(2, 1, 0);
        pa(3, 9, 0);
        pa(1, 10, 1);
        pa(2, 17, 1);
        pa(2, 25, '1);
        axw(`FB_CTRL, 32'h1, r);
        wait (nobs == 4);
        axw(`FB_CTRL, 32'h2, r);
        fin(1, 2);
        stop_test;
    end
endmodule
